// *** inc/tcu_pkg.sv ***
// package: register indices, field positions, codes and state layout of the capture/compare timer
package tcu_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DIR      = 6'h00;
  localparam logic [5:0] IDX_FORCE    = 6'h01;
  localparam logic [5:0] IDX_OVR_MASK = 6'h02;
  localparam logic [5:0] IDX_OVR_VAL  = 6'h03;
  localparam logic [5:0] IDX_CNT      = 6'h04;
  localparam logic [5:0] IDX_CNT_LO   = 6'h05;
  localparam logic [5:0] IDX_CTL_ONE  = 6'h06;
  localparam logic [5:0] IDX_TOV      = 6'h07;
  localparam logic [5:0] IDX_ACT_HI   = 6'h08;
  localparam logic [5:0] IDX_ACT_LO   = 6'h09;
  localparam logic [5:0] IDX_EDG_HI   = 6'h0a;
  localparam logic [5:0] IDX_EDG_LO   = 6'h0b;
  localparam logic [5:0] IDX_IE       = 6'h0c;
  localparam logic [5:0] IDX_CTL_TWO  = 6'h0d;
  localparam logic [5:0] IDX_FLG      = 6'h0e;
  localparam logic [5:0] IDX_OVF      = 6'h0f;
  localparam logic [5:0] IDX_TC_FIRST = 6'h10;
  localparam logic [5:0] IDX_TC_LAST  = 6'h1f;
  localparam logic [5:0] IDX_ACC_CTL  = 6'h20;
  localparam logic [5:0] IDX_ACC_FLG  = 6'h21;
  localparam logic [5:0] IDX_ACC_CNT  = 6'h22;
  localparam logic [5:0] IDX_ACC_LO   = 6'h23;
  localparam logic [5:0] IDX_PIN_DIS  = 6'h2c;
  localparam logic [5:0] IDX_PSC      = 6'h2e;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL1_EN   = 7;
  localparam int CTL1_WAIT = 6;
  localparam int CTL1_FRZ  = 5;
  localparam int CTL1_FFCA = 4;
  localparam int CTL1_PREC = 3;
  localparam int CTL2_OVIE = 7;
  localparam int CTL2_CRST = 3;
  localparam int OVF_FLAG  = 7;
  localparam int ACC_EN    = 6;
  localparam int ACC_MOD   = 5;
  localparam int ACC_EDGE  = 4;
  localparam int ACC_CLK_H = 3;
  localparam int ACC_CLK_L = 2;
  localparam int ACC_OVI   = 1;
  localparam int ACC_AI    = 0;
  localparam int AFLG_OVF  = 1;
  localparam int AFLG_IF   = 0;

  // ----------------------------------------------------------------
  // channels, codes, counts
  // ----------------------------------------------------------------
  localparam int          NUM_CH    = 8;
  localparam logic [7:0]  CH_MASK   = 8'hff;
  localparam logic [1:0]  EDGE_RISE = 2'h1;
  localparam logic [1:0]  EDGE_FALL = 2'h2;
  localparam logic [1:0]  EDGE_ANY  = 2'h3;
  localparam logic [1:0]  ACT_TOG   = 2'h1;
  localparam logic [1:0]  ACT_CLR   = 2'h2;
  localparam logic [1:0]  ACT_SET   = 2'h3;
  localparam logic [5:0]  GATE_DIV_M1 = 6'h3f;
  localparam logic [15:0] CNT_MAX   = 16'hffff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } tcu_pin_out_t;

  typedef struct packed {
    logic [7:0]       dir_sel;
    logic [7:0]       ovr_mask;
    logic [7:0]       ovr_val;
    logic [15:0]      cnt;
    logic             tmr_en;
    logic             wait_halt;
    logic             frz_halt;
    logic             fast_clr;
    logic             prec_sel;
    logic [7:0]       tog_ovf;
    logic [15:0]      act;
    logic [15:0]      edg;
    logic [7:0]       ch_ie;
    logic             ovf_ie;
    logic             cmp_rst;
    logic [2:0]       pr;
    logic [7:0]       cflg;
    logic             ovf_flag;
    logic [7:0][15:0] tc;
    logic [6:0]       acc_ctl;
    logic             acc_ovf;
    logic             acc_if;
    logic [15:0]      acc_cnt;
    logic [7:0]       pin_dis;
    logic [7:0]       psc_sel;
    logic [7:0]       psc_cnt;
    logic [5:0]       gate_div;
    logic [7:0]       pin_prev;
    logic [7:0]       pin_out;
    logic             wr_pend;
    logic             rd_pend;
    logic [5:0]       a_idx;
    logic [31:0]      hrdata;
  } tcu_state_t;

endpackage : tcu_pkg

// *** design/tcu_timer.sv ***
// eight-channel capture/compare timer with pulse accumulator and AHB-Lite register slave
// Contract
// - 16-bit counter runs from module clock through a programmable prescaler.
// - eight channels, each usable as input capture or output compare.
// - 16-bit pulse accumulator counts events or gated time.
// - accumulator input is channel 7 pin only, shared with that channel.
// - capture channel records counter value on its selected pin edge.
// - compare channel changes its pin or just flags for software delays.
// - counter and channel values are read and written as whole words; the code also has low-byte registers (IDX_CNT_LO, odd channel indices).
// - stop mode halts all timer activity.
// - freeze mode halts counter only when freeze-halt bit is one.
// - wait mode halts counter only when wait-halt bit is one.
// - counter runs while enable bit is one, stops when it is zero.
// - direction bit 0 means input capture, 1 means output compare.
// - bits of absent channels ignore writes and read as zero.
// - a channel value register exists only for a present channel.
// - each register decoded as module base plus fixed offset.
// - force write performs channel compare action at once, no flag set.
// - force register always reads zero.
// - main counter counts upward.
// - counter writes ignored in normal mode, accepted in special mode.
//
// Design decision made here: register access over AHB-Lite.
module tcu_timer
  import tcu_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic         stop_mode,
  input  wire logic         freeze_mode,
  input  wire logic         wait_mode,
  input  wire logic         special_mode,
  input  wire logic [7:0]   ioc_i,
  output tcu_pin_out_t      ioc,
  output logic [7:0]        chan_irq,
  output logic              ovf_irq,
  output logic              acc_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    logic hit;
    hit = 1'b0;
    case (sel)
      EDGE_RISE: hit = !prev && now;
      EDGE_FALL: hit = prev && !now;
      EDGE_ANY:  hit = prev != now;
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  function automatic logic act_apply(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (act)
      ACT_TOG: res = !cur;
      ACT_CLR: res = 1'b0;
      ACT_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction : act_apply

  tcu_state_t  q;
  tcu_state_t  d;
  logic        take;
  logic        run;
  logic        tick;
  logic [7:0]  div_m1;
  logic        ovf;
  logic        cmp_rst_hit;
  logic        ev7;
  logic        cnt_wr;
  logic [7:0]  cmp_hit;
  logic [7:0]  cap_hit;
  logic [7:0]  force_w;
  logic [7:0]  wd8;
  logic [15:0] wd16;
  logic        acc_on;
  logic        acc_edge;
  logic        gate_on;
  logic        acc_inc;
  logic [2:0]  ch_sel;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    wd8      = hwdata[7:0] & CH_MASK;
    wd16     = hwdata[15:0];
    ch_sel   = q.a_idx[3:1];
    take     = hsel && htrans[1] && hready;
    // whole-word access keeps the 16-bit values coherent
    d.wr_pend = take && hwrite;
    d.rd_pend = take && !hwrite;
    if (take) begin
      d.a_idx = haddr[7:2];
    end

    // counter gating by modes and enable
    run    = q.tmr_en && !stop_mode && !(freeze_mode && q.frz_halt)
             && !(wait_mode && q.wait_halt);
    div_m1 = q.prec_sel ? q.psc_sel : 8'((8'h01 << q.pr) - 8'h01);
    tick   = run && (q.psc_cnt == div_m1);
    if (run) begin
      d.psc_cnt = tick ? 8'h00 : 8'(q.psc_cnt + 8'h01);
    end

    cmp_hit = '0;
    cap_hit = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      cmp_hit[ch] = tick && q.dir_sel[ch] && CH_MASK[ch] && (q.cnt == q.tc[ch]);
      cap_hit[ch] = !stop_mode && !q.dir_sel[ch] && CH_MASK[ch]
                    && edge_hit(q.edg[2*ch +: 2], q.pin_prev[ch], ioc_i[ch]);
    end
    ovf      = tick && (q.cnt == CNT_MAX);
    cmp_rst_hit = tick && q.cmp_rst && cmp_hit[7];
    if (cmp_rst_hit) begin
      d.cnt = 16'h0000;
    end else if (tick) begin
      d.cnt = 16'(q.cnt + 16'h0001);
    end

    // output actions: overflow toggle, then compare or force, then channel 7 override
    force_w = (q.wr_pend && q.a_idx == IDX_FORCE) ? wd8 : 8'h00;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (ovf && q.tog_ovf[ch]) begin
        d.pin_out[ch] = !d.pin_out[ch];
      end
      if (force_w[ch] || cmp_hit[ch]) begin
        d.pin_out[ch] = act_apply(q.act[2*ch +: 2], d.pin_out[ch]);
      end
    end
    ev7 = cmp_hit[7] || force_w[7] || (ovf && q.tog_ovf[7]);
    if (ev7) begin
      d.pin_out = (d.pin_out & ~q.ovr_mask) | (q.ovr_val & q.ovr_mask);
    end
    if (stop_mode) begin
      d.pin_out = q.pin_out;
    end
    d.pin_prev = ioc_i;

    // pulse accumulator on the channel 7 pin
    acc_on   = q.acc_ctl[ACC_EN] && !stop_mode;
    acc_edge = q.acc_ctl[ACC_EDGE] ? (!q.pin_prev[7] && ioc_i[7])
                                   : (q.pin_prev[7] && !ioc_i[7]);
    gate_on  = q.acc_ctl[ACC_EDGE] ? !ioc_i[7] : ioc_i[7];
    acc_inc  = 1'b0;
    if (acc_on && q.acc_ctl[ACC_MOD]) begin
      d.gate_div = 6'(q.gate_div + 6'h01);
      acc_inc    = gate_on && (q.gate_div == GATE_DIV_M1);
    end else if (acc_on) begin
      acc_inc = acc_edge;
    end
    if (acc_inc) begin
      d.acc_cnt = 16'(q.acc_cnt + 16'h0001);
    end

    // register writes, data phase
    cnt_wr = 1'b0;
    if (q.wr_pend) begin
      if (q.a_idx == IDX_DIR) begin
        d.dir_sel = wd8;
      end else if (q.a_idx == IDX_OVR_MASK) begin
        d.ovr_mask = wd8;
      end else if (q.a_idx == IDX_OVR_VAL) begin
        d.ovr_val = wd8;
      end else if (q.a_idx == IDX_CNT) begin
        cnt_wr = special_mode;
        if (special_mode) begin
          d.cnt = wd16;
        end
      end else if (q.a_idx == IDX_CNT_LO) begin
        cnt_wr = special_mode;
        if (special_mode) begin
          d.cnt[7:0] = hwdata[7:0];
        end
      end else if (q.a_idx == IDX_CTL_ONE) begin
        d.tmr_en    = hwdata[CTL1_EN];
        d.wait_halt = hwdata[CTL1_WAIT];
        d.frz_halt  = hwdata[CTL1_FRZ];
        d.fast_clr  = hwdata[CTL1_FFCA];
        d.prec_sel  = hwdata[CTL1_PREC];
      end else if (q.a_idx == IDX_TOV) begin
        d.tog_ovf = wd8;
      end else if (q.a_idx == IDX_ACT_HI) begin
        d.act[15:8] = hwdata[7:0];
      end else if (q.a_idx == IDX_ACT_LO) begin
        d.act[7:0] = hwdata[7:0];
      end else if (q.a_idx == IDX_EDG_HI) begin
        d.edg[15:8] = hwdata[7:0];
      end else if (q.a_idx == IDX_EDG_LO) begin
        d.edg[7:0] = hwdata[7:0];
      end else if (q.a_idx == IDX_IE) begin
        d.ch_ie = wd8;
      end else if (q.a_idx == IDX_CTL_TWO) begin
        d.ovf_ie  = hwdata[CTL2_OVIE];
        d.cmp_rst = hwdata[CTL2_CRST];
        d.pr   = hwdata[2:0];
      end else if (q.a_idx == IDX_FLG) begin
        d.cflg = q.cflg & ~wd8;
      end else if (q.a_idx == IDX_OVF) begin
        d.ovf_flag = q.ovf_flag && !hwdata[OVF_FLAG];
      end else if (q.a_idx >= IDX_TC_FIRST && q.a_idx <= IDX_TC_LAST) begin
        if (CH_MASK[ch_sel] && q.a_idx[0]) begin
          d.tc[ch_sel][7:0] = hwdata[7:0];
        end else if (CH_MASK[ch_sel]) begin
          d.tc[ch_sel] = wd16;
        end
      end else if (q.a_idx == IDX_ACC_CTL) begin
        d.acc_ctl = hwdata[6:0];
      end else if (q.a_idx == IDX_ACC_FLG) begin
        d.acc_ovf = q.acc_ovf && !hwdata[AFLG_OVF];
        d.acc_if  = q.acc_if && !hwdata[AFLG_IF];
      end else if (q.a_idx == IDX_ACC_CNT) begin
        d.acc_cnt = wd16;
      end else if (q.a_idx == IDX_ACC_LO) begin
        d.acc_cnt[7:0] = hwdata[7:0];
      end else if (q.a_idx == IDX_PIN_DIS) begin
        d.pin_dis = wd8;
      end else if (q.a_idx == IDX_PSC) begin
        d.psc_sel = hwdata[7:0];
      end
    end

    // hardware events last so a set beats a same-cycle clear or write
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (cap_hit[ch]) begin
        d.tc[ch] = q.cnt;
      end
    end
    d.cflg  = d.cflg | cap_hit | (cmp_hit & ~force_w);
    d.ovf_flag = d.ovf_flag || ovf;
    d.acc_ovf  = d.acc_ovf || (acc_inc && q.acc_cnt == CNT_MAX);
    d.acc_if   = d.acc_if || (acc_on && acc_edge);

    // read mux, loaded during the single wait state
    rdata = 32'h0000_0000;
    if (q.a_idx == IDX_DIR) begin
      rdata[7:0] = q.dir_sel & CH_MASK;
    end else if (q.a_idx == IDX_FORCE) begin
      rdata = 32'h0000_0000;
    end else if (q.a_idx == IDX_OVR_MASK) begin
      rdata[7:0] = q.ovr_mask & CH_MASK;
    end else if (q.a_idx == IDX_OVR_VAL) begin
      rdata[7:0] = q.ovr_val & CH_MASK;
    end else if (q.a_idx == IDX_CNT) begin
      rdata[15:0] = q.cnt;
    end else if (q.a_idx == IDX_CNT_LO) begin
      rdata[7:0] = q.cnt[7:0];
    end else if (q.a_idx == IDX_CTL_ONE) begin
      rdata[7:0] = {q.tmr_en, q.wait_halt, q.frz_halt, q.fast_clr, q.prec_sel, 3'h0};
    end else if (q.a_idx == IDX_TOV) begin
      rdata[7:0] = q.tog_ovf & CH_MASK;
    end else if (q.a_idx == IDX_ACT_HI) begin
      rdata[7:0] = q.act[15:8];
    end else if (q.a_idx == IDX_ACT_LO) begin
      rdata[7:0] = q.act[7:0];
    end else if (q.a_idx == IDX_EDG_HI) begin
      rdata[7:0] = q.edg[15:8];
    end else if (q.a_idx == IDX_EDG_LO) begin
      rdata[7:0] = q.edg[7:0];
    end else if (q.a_idx == IDX_IE) begin
      rdata[7:0] = q.ch_ie & CH_MASK;
    end else if (q.a_idx == IDX_CTL_TWO) begin
      rdata[7:0] = {q.ovf_ie, 3'h0, q.cmp_rst, q.pr};
    end else if (q.a_idx == IDX_FLG) begin
      rdata[7:0] = q.cflg & CH_MASK;
    end else if (q.a_idx == IDX_OVF) begin
      rdata[OVF_FLAG] = q.ovf_flag;
    end else if (q.a_idx >= IDX_TC_FIRST && q.a_idx <= IDX_TC_LAST) begin
      if (CH_MASK[ch_sel] && q.a_idx[0]) begin
        rdata[7:0] = q.tc[ch_sel][7:0];
      end else if (CH_MASK[ch_sel]) begin
        rdata[15:0] = q.tc[ch_sel];
      end
    end else if (q.a_idx == IDX_ACC_CTL) begin
      rdata[6:0] = q.acc_ctl;
    end else if (q.a_idx == IDX_ACC_FLG) begin
      rdata[1:0] = {q.acc_ovf, q.acc_if};
    end else if (q.a_idx == IDX_ACC_CNT) begin
      rdata[15:0] = q.acc_cnt;
    end else if (q.a_idx == IDX_ACC_LO) begin
      rdata[7:0] = q.acc_cnt[7:0];
    end else if (q.a_idx == IDX_PIN_DIS) begin
      rdata[7:0] = q.pin_dis & CH_MASK;
    end else if (q.a_idx == IDX_PSC) begin
      rdata[7:0] = q.psc_sel;
    end
    if (q.rd_pend) begin
      d.hrdata = rdata;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a read costs one wait state so read data always comes from a flop
  assign hreadyout = !q.rd_pend;
  assign hresp     = 1'b0;
  assign hrdata    = q.hrdata;
  assign ioc.o     = q.pin_out;
  // channel 7 stops driving while the accumulator owns its pin
  assign ioc.oe    = q.dir_sel & ~q.pin_dis & CH_MASK & {!q.acc_ctl[ACC_EN], 7'h7f};
  assign chan_irq  = q.cflg & q.ch_ie;
  assign ovf_irq   = q.ovf_flag && q.ovf_ie;
  assign acc_irq   = (q.acc_ovf && q.acc_ctl[ACC_OVI]) || (q.acc_if && q.acc_ctl[ACC_AI]);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_take;
    take && !hwrite;
  endsequence
  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence

  a_stop_halts_cnt: assert property ((stop_mode && !cnt_wr) |=> $stable(q.cnt))
    else $error("counter moved in stop mode");
  a_freeze_halts_cnt: assert property ((freeze_mode && q.frz_halt && !cnt_wr) |=> $stable(q.cnt))
    else $error("counter moved in freeze with halt bit set");
  a_wait_halts_cnt: assert property ((wait_mode && q.wait_halt && !cnt_wr) |=> $stable(q.cnt))
    else $error("counter moved in wait with halt bit set");
  a_disabled_cnt_holds: assert property ((!q.tmr_en && !cnt_wr) |=> $stable(q.cnt))
    else $error("counter moved while disabled");
  a_cnt_counts_up: assert property ((tick && !cmp_rst_hit && !cnt_wr)
                                    |=> q.cnt == 16'($past(q.cnt) + 16'h0001))
    else $error("counter did not step up by one");
  a_normal_wr_ignored: assert property ((q.wr_pend && q.a_idx == IDX_CNT && !special_mode && !run)
                                        |=> $stable(q.cnt))
    else $error("counter write accepted in normal mode");
  a_force_reads_zero: assert property ((q.rd_pend && q.a_idx == IDX_FORCE) |=> hrdata == 32'h0)
    else $error("force register read nonzero");
  a_capture_records_cnt: assert property (cap_hit[2] |=> (q.tc[2] == $past(q.cnt)) && q.cflg[2])
    else $error("capture value or flag wrong");
  a_force_sets_no_flag: assert property ((force_w[0] && !cap_hit[0] && !q.cflg[0]) |=> !q.cflg[0])
    else $error("forced compare set a flag");
  a_read_wait_state: assert property (s_read_take |=> s_read_done)
    else $error("read answer not after one wait state");
  a_capture_no_drive: assert property (!q.dir_sel[3] |-> !ioc.oe[3])
    else $error("capture channel drives its pin");
  a_flag_requests_irq: assert property ((q.cflg[0] && q.ch_ie[0]) |-> chan_irq[0])
    else $error("enabled flag gives no request");

endmodule : tcu_timer

// *** tb/tcu_timer_tb_top.sv ***
// self-checking bench for the capture/compare timer: register bus, modes and pins
module tcu_timer_tb_top;
  import tcu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         stop_mode;
  logic         freeze_mode;
  logic         wait_mode;
  logic         special_mode;
  logic [7:0]   ioc_i;
  tcu_pin_out_t ioc;
  logic [7:0]   chan_irq;
  logic         ovf_irq;
  logic         acc_irq;
  logic         rd_phase;
  logic [31:0]  exp_q[$];
  int           mismatches;
  int           checked;
  int           cycles;
  logic [7:0]   r;

  tcu_timer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .freeze_mode(freeze_mode), .wait_mode(wait_mode), .special_mode(special_mode),
    .ioc_i(ioc_i), .ioc(ioc), .chan_irq(chan_irq), .ovf_irq(ovf_irq), .acc_irq(acc_irq)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  // watcher: each completed read takes the oldest note off the queue
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      chk("hresp", 32'h0, {31'h0, hresp});
      if (exp_q.size() == 0) begin
        chk("read note", 32'h1, 32'h0);
      end else begin
        chk("hrdata", exp_q.pop_front(), hrdata);
      end
    end
  end

  // ----------------------------------------------------------------
  // bus master: single word transfers, held until hready is sampled high
  // ----------------------------------------------------------------
  task automatic xfer(input logic is_wr, input logic [5:0] idx, input logic [31:0] data);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= is_wr;
    hsize  <= 3'h2;
    haddr  <= {24'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans   <= 2'b00;
    hsel     <= 1'b0;
    hwdata   <= is_wr ? data : 32'h0;
    rd_phase <= ~is_wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [31:0] data);
    xfer(1'b1, idx, data);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, idx, 32'h0);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask : settle

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    stop_mode    = 1'b0;
    freeze_mode  = 1'b0;
    wait_mode    = 1'b0;
    special_mode = 1'b0;
    ioc_i        = 8'h00;
    rd_phase     = 1'b0;
    mismatches   = 0;
    checked      = 0;
    cycles       = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    r = 8'($urandom(32'h429a4e3e));
    rd(IDX_DIR, 32'h0);
    rd(IDX_CTL_ONE, 32'h0);
    rd(IDX_CNT, 32'h0);
    rd(IDX_FLG, 32'h0);
    wr(IDX_FORCE, 32'hff);
    rd(IDX_FORCE, 32'h0);
    wr(6'h24, 32'hffff);
    rd(6'h24, 32'h0);
    repeat (3) begin
      r = 8'($urandom());
      wr(IDX_DIR, {24'h0, r});
      rd(IDX_DIR, {24'h0, r & CH_MASK});
    end
    // ch0 and ch1 compare, ch2 capture on rising edge
    wr(IDX_DIR, 32'h03);
    wr(IDX_ACT_LO, 32'h07);
    wr(IDX_EDG_LO, 32'h10);
    wr(IDX_IE, 32'h01);
    wr(IDX_CNT, 32'h5555);
    rd(IDX_CNT, 32'h0);
    special_mode <= 1'b1;
    wr(IDX_CNT, 32'h0100);
    special_mode <= 1'b0;
    rd(IDX_CNT, 32'h0100);
    ioc_i[2] <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(IDX_TC_FIRST + 6'h4, 32'h0100);
    rd(IDX_FLG, 32'h04);
    wr(IDX_FLG, 32'h04);
    wr(IDX_TC_FIRST, 32'h0110);
    // each hold mode keeps the counter still although the timer is enabled
    stop_mode <= 1'b1;
    wr(IDX_CTL_ONE, 32'he0);
    repeat (30) @(posedge hclk);
    rd(IDX_CNT, 32'h0100);
    chk("pin0 held", 32'h0, {31'h0, ioc.o[0]});
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    repeat (30) @(posedge hclk);
    rd(IDX_CNT, 32'h0100);
    wait_mode   <= 1'b0;
    freeze_mode <= 1'b1;
    repeat (30) @(posedge hclk);
    rd(IDX_CNT, 32'h0100);
    freeze_mode <= 1'b0;
    repeat (40) @(posedge hclk);
    rd(IDX_FLG, 32'h01);
    chk("pin0 set", 32'h1, {31'h0, ioc.o[0]});
    chk("pin0 driven", 32'h1, {31'h0, ioc.oe[0]});
    chk("channel request", 32'h01, {24'h0, chan_irq});
    wr(IDX_FLG, 32'h01);
    rd(IDX_FLG, 32'h0);
    chk("request cleared", 32'h0, {24'h0, chan_irq});
    wr(IDX_FORCE, 32'h02);
    settle();
    chk("pin1 forced", 32'h1, {31'h0, ioc.o[1]});
    rd(IDX_FLG, 32'h0);
    // channel 7 becomes a compare channel, but the accumulator owns its pin
    wr(IDX_DIR, 32'h83);
    wr(IDX_ACC_CTL, 32'h51);
    repeat (2) begin
      ioc_i[7] <= 1'b1;
      settle();
      ioc_i[7] <= 1'b0;
      settle();
    end
    rd(IDX_ACC_CNT, 32'h0002);
    chk("accumulator request", 32'h1, {31'h0, acc_irq});
    chk("pin7 released", 32'h0, {31'h0, ioc.oe[7]});
    // wrap through zero: overflow, then channel 1 and 7 compares at zero
    wr(IDX_CTL_TWO, 32'h80);
    special_mode <= 1'b1;
    wr(IDX_CNT, 32'hfff0);
    special_mode <= 1'b0;
    repeat (40) @(posedge hclk);
    chk("overflow request", 32'h1, {31'h0, ovf_irq});
    chk("pin1 compare", 32'h0, {31'h0, ioc.o[1]});
    rd(IDX_FLG, 32'h82);
    @(posedge hclk);
    conclude();
  end

endmodule : tcu_timer_tb_top
